// ---- core/pte_frame.sv ----
// Purpose: Common control frame of one on-chip peripheral
// Assumes: Bus request held until ready; toggle inputs reset low
// Notes:   Summary of operation below
//
// Summary of operation
// [R01] Decode own 4 KiB window, 1024 words
// [R02] Identifier is base offset over window size
// [R03] Software enables one peripheral per shared identifier
// [R04] Switch: disable, unlink, clear enables, configure, enable
// [R05] Software configures before setting the enable
// [R06] Disabled peripheral ignores tasks, makes no events
// [R07] Set-and-clear triplet: main, set, clear
// [R08] Ones set or clear bits; zeros change nothing
// [R09] Set and clear aliases read the main value
// [R10] Task fires on write 1 or input toggle
// [R11] Each task and event has own register
// [R12] Event toggle sets its event register
// [R13] Event register cleared only by writing 0
// [R14] Event pulse still emitted when already set
// [R15] Enabled hardwired shortcut fires task on event
// [R16] One shortcut register, one bit, max 32
// [R17] One interrupt line, number equals identifier
// [R18] Any enabled pending event raises the interrupt
// [R19] One fixed bit per event in enable triplet
// [R20] Enable aliases read back the enable state
// [R21] Interrupt drops within four cycles of clearing
// [R22] Software reads back after clearing
// [R23] Interrupt is OR of event AND enable
`timescale 1ns/1ps
`include "pte_regs.svh"
module pte_frame
  import pte_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR  = `PTE_DEF_BASE,
  parameter int          N_TASK     = 4,
  parameter int          N_EVT      = 4,
  parameter int          N_SHORT    = 4,
  parameter logic [31:0] CONFIG_RST = `PTE_RST_WORD
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // Register bus and interrupt
  pte_bus_if.dev                 bus,
  // Hardware tasks and events
  input  wire logic [N_TASK-1:0] i_task_hw,
  input  wire logic [N_EVT-1:0]  i_evt_sig,
  output logic [N_TASK-1:0]      o_task,
  output logic [N_EVT-1:0]       o_evt,
  // Peripheral core control
  output logic                   o_enabled,
  output logic [31:0]            o_config,
  output logic [7:0]             o_irq_num
);

  // ------------------------------------------------------------
  // Identity
  // ------------------------------------------------------------
  localparam pte_id_type PERIPH_ID =
    8'((BASE_ADDR - `PTE_ID_ORIGIN) >> `PTE_WIN_SHIFT);   // [R02]

  pte_off_type        off;
  logic               hit;
  logic               acc;
  logic               wr;
  logic               ready_q;
  logic               enable;
  logic [N_SHORT-1:0] short_en;
  logic [N_EVT-1:0]   irq_en;
  logic [N_EVT-1:0]   evt_reg;
  logic [N_TASK-1:0]  task_hw_q;
  logic [N_EVT-1:0]   evt_sig_q;
  logic [N_EVT-1:0]   evt_fire;
  logic [N_TASK-1:0]  sw_task;
  logic [N_TASK-1:0]  sc_task;
  logic [N_EVT-1:0]   evt_clear;
  logic [31:0]        next_rdata;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // Upper bits select the window, low 12 bits the word slot
  assign hit = bus.sel
    && (bus.addr[31:`PTE_WIN_SHIFT] == BASE_ADDR[31:`PTE_WIN_SHIFT]); // [R01]
  assign off = bus.addr[11:0];
  assign acc = hit && !ready_q;
  assign wr  = acc && bus.we;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ready_q   <= `PTE_RST_BIT;
      bus.rdata <= `PTE_RST_WORD;
    end else begin
      ready_q <= acc;
      if (acc) begin
        bus.rdata <= next_rdata;
      end
    end
  end

  assign bus.ready = ready_q;
  assign o_irq_num = PERIPH_ID;   // [R17]

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always_comb begin
    next_rdata = `PTE_RST_WORD;
    if (!bus.we) begin
      for (int e = 0; e < N_EVT; e++) begin
        if (off == 12'(`PTE_OFF_EVT + `PTE_SLOT_STEP * e)) begin
          next_rdata = {31'h0000_0000, evt_reg[e]};   // [R11]
        end
      end
      unique case (off)
        `PTE_OFF_SHORTS:       next_rdata = 32'(short_en);
        // All three slots show the same enable bits [R09] [R20]
        `PTE_OFF_IRQ_EN,
        `PTE_OFF_IRQ_EN_SET,
        `PTE_OFF_IRQ_EN_CLEAR: next_rdata = 32'(irq_en);
        `PTE_OFF_IDREG:        next_rdata = 32'(PERIPH_ID);
        `PTE_OFF_ENABLE:       next_rdata = 32'(enable);
        `PTE_OFF_CONFIG:       next_rdata = o_config;
        default:               next_rdata = next_rdata;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  // Ordering of configure and enable is left to software [R05]
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      enable   <= `PTE_RST_BIT;
      o_config <= CONFIG_RST;
      short_en <= N_SHORT'(`PTE_RST_WORD);
    end else if (wr) begin
      unique case (off)
        `PTE_OFF_ENABLE: enable   <= bus.wdata[0];
        `PTE_OFF_CONFIG: o_config <= bus.wdata;
        `PTE_OFF_SHORTS: short_en <= bus.wdata[N_SHORT-1:0];   // [R16]
        default:         enable   <= enable;
      endcase
    end
  end

  assign o_enabled = enable;

  // ------------------------------------------------------------
  // Interrupt enable triplet
  // ------------------------------------------------------------
  // Bit e of all three slots belongs to event e [R19]
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_en <= N_EVT'(`PTE_RST_WORD);   // [R23]
    end else if (wr) begin
      unique case (off)
        `PTE_OFF_IRQ_EN:       irq_en <= bus.wdata[N_EVT-1:0];
        // Set alias follows main, clear alias follows set [R07]
        // Ones act, zeros leave bits alone [R08]
        `PTE_OFF_IRQ_EN_SET:   irq_en <= irq_en | bus.wdata[N_EVT-1:0];
        `PTE_OFF_IRQ_EN_CLEAR: irq_en <= irq_en & ~bus.wdata[N_EVT-1:0];
        default:               irq_en <= irq_en;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Events
  // ------------------------------------------------------------
  // A toggle of the core's event line is one event
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      evt_sig_q <= N_EVT'(`PTE_RST_WORD);
      task_hw_q <= N_TASK'(`PTE_RST_WORD);
    end else begin
      evt_sig_q <= i_evt_sig;
      task_hw_q <= i_task_hw;
    end
  end

  assign evt_fire = (i_evt_sig ^ evt_sig_q) & {N_EVT{enable}};   // [R06]

  always_comb begin
    for (int e = 0; e < N_EVT; e++) begin
      evt_clear[e] = wr && !bus.wdata[0]
        && (off == 12'(`PTE_OFF_EVT + `PTE_SLOT_STEP * e));       // [R13]
    end
  end

  // A new event beats a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      evt_reg <= N_EVT'(`PTE_RST_WORD);   // [R23]
    end else begin
      evt_reg <= (evt_reg & ~evt_clear) | evt_fire;   // [R12] [R13]
    end
  end

  // Pulse goes out even when the register already holds 1 [R14]
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_evt <= N_EVT'(`PTE_RST_WORD);
    end else begin
      o_evt <= evt_fire;   // [R14]
    end
  end

  // ------------------------------------------------------------
  // Tasks and shortcuts
  // ------------------------------------------------------------
  always_comb begin
    for (int t = 0; t < N_TASK; t++) begin
      sw_task[t] = wr && bus.wdata[0]
        && (off == 12'(`PTE_OFF_TASK + `PTE_SLOT_STEP * t));       // [R10] [R11]
    end
  end

  // Fixed map: shortcut k links event k mod N_EVT to task k mod N_TASK
  always_comb begin
    sc_task = N_TASK'(`PTE_RST_WORD);
    for (int k = 0; k < N_SHORT && k < `PTE_MAX_SHORTS; k++) begin
      if (short_en[k] && evt_fire[k % N_EVT]) begin
        sc_task[k % N_TASK] = 1'b1;   // [R15]
      end
    end
  end

  // Disabled frame swallows every trigger source
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_task <= N_TASK'(`PTE_RST_WORD);
    end else if (enable) begin
      o_task <= sw_task | (i_task_hw ^ task_hw_q) | sc_task;   // [R10] [R06]
    end else begin
      o_task <= N_TASK'(`PTE_RST_WORD);   // [R06]
    end
  end

  // ------------------------------------------------------------
  // Interrupt
  // ------------------------------------------------------------
  // Registered once: drops one cycle after the clearing write,
  // well inside the four-cycle allowance
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bus.irq <= `PTE_RST_BIT;
    end else begin
      bus.irq <= |(evt_reg & irq_en);   // [R18] [R21] [R23]
    end
  end

endmodule

// ---- core/pte_host.sv ----
// Purpose: Processor-side end that drives the peripheral bus
// Assumes: One access at a time, i_req only in idle
// Notes:   Optional read-back after clearing writes
`timescale 1ns/1ps
`include "pte_regs.svh"
module pte_host
  import pte_pkg::*;
#(
  parameter bit READBACK = 1'b1,
  parameter int TIMEOUT  = `PTE_BUS_TIMEOUT
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Bus
  pte_bus_if.host           bus,
  // User requests
  input  wire logic         i_req,
  input  wire logic         i_we,
  input  wire logic [31:0]  i_addr,
  input  wire logic [31:0]  i_wdata,
  // User answers
  output logic [31:0]       o_rdata,
  output logic              o_done,
  output logic              o_err,
  output logic              o_busy,
  output logic              o_irq
);

  pte_host_state_type state;
  logic [7:0]         wait_cnt;
  logic               need_rb;
  logic               clear_write;
  logic               timed_out;

  // ------------------------------------------------------------
  // Clearing writes
  // ------------------------------------------------------------
  // A write of 0 to an event slot or any write to the enable clear alias
  always_comb begin
    clear_write = 1'b0;
    if (i_addr[11:0] == `PTE_OFF_IRQ_EN_CLEAR) begin
      clear_write = 1'b1;
    end
    if ((i_addr[11:0] & `PTE_GROUP_MASK) == `PTE_OFF_EVT
        && i_wdata == `PTE_RST_WORD) begin
      clear_write = 1'b1;
    end
  end

  assign timed_out = (wait_cnt == 8'(TIMEOUT - 1));
  assign o_busy    = (state != PTE_IDLE);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state     <= PTE_IDLE;
      bus.sel   <= `PTE_RST_BIT;
      bus.we    <= `PTE_RST_BIT;
      bus.addr  <= `PTE_RST_WORD;
      bus.wdata <= `PTE_RST_WORD;
      need_rb   <= `PTE_RST_BIT;
      wait_cnt  <= 8'h00;
      o_rdata   <= `PTE_RST_WORD;
      o_done    <= `PTE_RST_BIT;
      o_err     <= `PTE_RST_BIT;
    end else begin
      o_done <= 1'b0;
      unique case (state)
        PTE_IDLE: begin
          wait_cnt <= 8'h00;
          if (i_req) begin
            state     <= PTE_ACCESS;
            bus.sel   <= 1'b1;
            bus.we    <= i_we;
            bus.addr  <= i_addr;
            bus.wdata <= i_wdata;
            // Read-back makes the interrupt drop before return [R22]
            need_rb   <= READBACK && i_we && clear_write;
            o_err     <= 1'b0;
          end
        end
        PTE_ACCESS, PTE_READBACK: begin
          wait_cnt <= wait_cnt + 8'h01;
          if (bus.ready) begin
            wait_cnt <= 8'h00;
            o_rdata  <= bus.rdata;
            if (need_rb) begin
              state   <= PTE_READBACK;
              bus.we  <= 1'b0;
              need_rb <= 1'b0;
            end else begin
              state   <= PTE_FINISH;
              bus.sel <= 1'b0;
            end
          end else if (timed_out) begin
            // Address outside every window never answers
            state   <= PTE_FINISH;
            bus.sel <= 1'b0;
            o_err   <= 1'b1;
          end
        end
        PTE_FINISH: begin
          state  <= PTE_IDLE;
          o_done <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_irq <= `PTE_RST_BIT;
    end else begin
      o_irq <= bus.irq;
    end
  end

endmodule

// ---- include/pte_bus_if.sv ----
// Purpose: Peripheral bus between processor side and one frame
// Assumes: One clock, request held until ready
// Notes:   Interrupt line travels with the bus
`timescale 1ns/1ps
interface pte_bus_if;
  logic        sel;
  logic        we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        ready;
  logic        irq;

  modport dev (
    input  sel,
    input  we,
    input  addr,
    input  wdata,
    output rdata,
    output ready,
    output irq
  );

  modport host (
    output sel,
    output we,
    output addr,
    output wdata,
    input  rdata,
    input  ready,
    input  irq
  );
endinterface

// ---- include/pte_pkg.sv ----
// Purpose: Shared types of the peripheral frame
// Assumes: Constants live in pte_regs.svh
// Notes:   Types only
package pte_pkg;

  typedef logic [31:0] pte_word_type;
  typedef logic [7:0]  pte_id_type;
  typedef logic [11:0] pte_off_type;

  typedef enum logic [1:0] {
    PTE_IDLE,
    PTE_ACCESS,
    PTE_READBACK,
    PTE_FINISH
  } pte_host_state_type;

endpackage

// ---- include/pte_regs.svh ----
// Purpose: Offsets, reset values and counts of the peripheral frame
// Assumes: Byte offsets inside one peripheral window
// Notes:   Definitions only
`ifndef PTE_REGS_SVH
`define PTE_REGS_SVH

// ------------------------------------------------------------
// Window and identity
// ------------------------------------------------------------
`define PTE_ID_ORIGIN        32'h4000_0000
`define PTE_WIN_SHIFT        12
`define PTE_DEF_BASE         32'h4000_1000

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define PTE_OFF_TASK         12'h000
`define PTE_OFF_EVT          12'h100
`define PTE_OFF_SHORTS       12'h200
`define PTE_OFF_IRQ_EN       12'h300
`define PTE_OFF_IRQ_EN_SET   12'h304
`define PTE_OFF_IRQ_EN_CLEAR 12'h308
`define PTE_OFF_IDREG        12'h400
`define PTE_OFF_ENABLE       12'h500
`define PTE_OFF_CONFIG       12'h504
`define PTE_SLOT_STEP        12'h004
`define PTE_GROUP_MASK       12'hF00

// ------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------
`define PTE_RST_WORD         32'h0000_0000
`define PTE_RST_BIT          1'b0
`define PTE_MAX_SHORTS       32
`define PTE_ALL_ONES         32'hFFFF_FFFF
`define PTE_BUS_TIMEOUT      16

`endif

// ---- sim/pte_frame_tb.sv ----
// Purpose: Host and frame joined, driven from host user side
// Assumes: Default base, four tasks and events
// Notes:   Pulse counters sampled on falling edge
`timescale 1ns/1ps
`include "pte_regs.svh"
module pte_frame_tb
  import pte_pkg::*;
;
  localparam logic [31:0] W = `PTE_DEF_BASE;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        req, we, done, err, busy, irq, enabled;
  logic [31:0] addr, wd, rdata, cfg;
  logic [3:0]  task_hw, evt_sig, o_task, o_evt;
  logic [7:0]  irq_num;
  int          miscompares = 0;
  int          compares = 0;
  int          n_task = 0;
  int          n_evt = 0;
  always #25 i_clk = ~i_clk;
  pte_bus_if bus();
  pte_host u_pte_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(bus),
    .i_req(req), .i_we(we), .i_addr(addr), .i_wdata(wd),
    .o_rdata(rdata), .o_done(done), .o_err(err), .o_busy(busy),
    .o_irq(irq));
  pte_frame u_pte_frame (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(bus),
    .i_task_hw(task_hw), .i_evt_sig(evt_sig), .o_task(o_task),
    .o_evt(o_evt), .o_enabled(enabled), .o_config(cfg),
    .o_irq_num(irq_num));
  pte_props u_pte_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .sel(bus.sel), .we(bus.we), .addr(bus.addr), .wdata(bus.wdata),
    .rdata(bus.rdata), .ready(bus.ready), .irq(bus.irq));
  always @(negedge i_clk) begin
    n_task += $countones(o_task);
    n_evt  += $countones(o_evt);
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [31:0] ra(input logic [11:0] o);
    return W + {20'h0, o};
  endfunction
  task automatic tally_and_finish();
    $display("Counts compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic op(input logic w, input logic [31:0] a,
                    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    req  <= 1'b1;
    we   <= w;
    addr <= a;
    wd   <= d;
    @(posedge i_clk);
    req <= 1'b0;
    @(negedge i_clk);
    chk("busy", 32'h1, {31'h0, busy});
    while (done !== 1'b1 && k < 40) begin
      @(negedge i_clk);
      k++;
    end
    if (k >= 40) begin
      miscompares++;
      $display("Error done expected 1 seen %b", done);
      tally_and_finish();
    end
  endtask
  task automatic rd(input string nm, input logic [11:0] o,
                    input logic [31:0] e);
    op(1'b0, ra(o), 32'h0);
    chk(nm, e, rdata);
  endtask
  task automatic tog(input logic t, input int i);
    @(posedge i_clk);
    if (t) task_hw <= task_hw ^ (4'h1 << i);
    else evt_sig <= evt_sig ^ (4'h1 << i);
    repeat (4) @(negedge i_clk);
  endtask
  task automatic ck_irq(input logic e);
    repeat (4) @(negedge i_clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {req, we, wd, task_hw, evt_sig} = '0;
    addr = W;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd("id", `PTE_OFF_IDREG, 32'h1);
    chk("irq_num", 32'h1, {24'h0, irq_num});
    rd("irq_en", `PTE_OFF_IRQ_EN, 32'h0);
    tog(1'b0, 0);
    tog(1'b1, 0);
    chk("evt_cnt", 0, n_evt);
    chk("task_cnt", 0, n_task);
    rd("evt0", `PTE_OFF_EVT, 32'h0);
    $display("Test disabled done");
    op(1'b1, ra(`PTE_OFF_CONFIG), 32'h0000_00A5);
    chk("config", 32'h0000_00A5, cfg);
    op(1'b1, ra(`PTE_OFF_ENABLE), 32'h1);
    chk("enabled", 32'h1, {31'h0, enabled});
    op(1'b1, ra(12'h004), 32'h1);
    op(1'b1, ra(12'h008), 32'h0);
    chk("task_cnt", 1, n_task);
    tog(1'b1, 2);
    chk("task_cnt", 2, n_task);
    tog(1'b0, 1);
    rd("evt1", 12'h104, 32'h1);
    rd("evt0", `PTE_OFF_EVT, 32'h0);
    tog(1'b0, 1);
    chk("evt_cnt", 2, n_evt);
    op(1'b1, ra(12'h104), 32'h1);
    rd("evt1", 12'h104, 32'h1);
    $display("Test tasks events done");
    op(1'b1, ra(`PTE_OFF_SHORTS), 32'h2);
    tog(1'b0, 1);
    chk("task_cnt", 3, n_task);
    op(1'b1, ra(`PTE_OFF_SHORTS), 32'h0);
    tog(1'b0, 1);
    chk("task_cnt", 3, n_task);
    $display("Test shortcuts done");
    ck_irq(1'b0);
    op(1'b1, ra(`PTE_OFF_IRQ_EN_SET), 32'h2);
    ck_irq(1'b1);
    op(1'b1, ra(`PTE_OFF_IRQ_EN_SET), 32'h1);
    rd("en_clr", `PTE_OFF_IRQ_EN_CLEAR, 32'h3);
    op(1'b1, ra(`PTE_OFF_IRQ_EN_CLEAR), 32'h1);
    rd("en_set", `PTE_OFF_IRQ_EN_SET, 32'h2);
    op(1'b1, ra(`PTE_OFF_IRQ_EN_CLEAR), `PTE_ALL_ONES);
    ck_irq(1'b0);
    op(1'b1, ra(`PTE_OFF_IRQ_EN_SET), 32'h2);
    ck_irq(1'b1);
    op(1'b1, ra(12'h104), 32'h0);
    ck_irq(1'b0);
    rd("evt1", 12'h104, 32'h0);
    $display("Test interrupt done");
    op(1'b1, ra(`PTE_OFF_ENABLE), 32'h0);
    chk("enabled", 32'h0, {31'h0, enabled});
    tog(1'b0, 1);
    chk("evt_cnt", 4, n_evt);
    op(1'b1, ra(`PTE_OFF_IRQ_EN_CLEAR), `PTE_ALL_ONES);
    op(1'b1, ra(`PTE_OFF_CONFIG), 32'h0000_005A);
    chk("config", 32'h0000_005A, cfg);
    op(1'b1, ra(`PTE_OFF_ENABLE), 32'h1);
    chk("enabled", 32'h1, {31'h0, enabled});
    rd("irq_en", `PTE_OFF_IRQ_EN, 32'h0);
    $display("Test switch done");
    rd("unmapped", 12'h600, 32'h0);
    rd("last", 12'hFFC, 32'h0);
    op(1'b1, 32'h4000_2000, 32'h1);
    chk("err", 32'h1, {31'h0, err});
    $display("Test window done");
    tally_and_finish();
  end
endmodule

// ---- sim/pte_props.sv ----
// Purpose: Bus and interrupt checks between host and frame
// Assumes: One clock, sync reset
// Notes:   Enable mirror built from observed writes
`timescale 1ns/1ps
`include "pte_regs.svh"
module pte_props
  import pte_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = `PTE_DEF_BASE,
  parameter int          N_EVT     = 4
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Bus
  input  wire logic        sel,
  input  wire logic        we,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic [31:0] rdata,
  input  wire logic        ready,
  input  wire logic        irq
);
  localparam logic [31:0] ID_VAL =
    (BASE_ADDR - `PTE_ID_ORIGIN) >> `PTE_WIN_SHIFT;
  localparam logic [31:0] EN_MASK = 32'((64'h1 << N_EVT) - 1);
  logic        in_win;
  logic [11:0] off;
  logic        wr_ok;
  logic        rd_ok;
  logic [31:0] en_m;
  assign in_win = (addr[31:12] == BASE_ADDR[31:12]);
  assign off    = addr[11:0];
  assign wr_ok  = sel && we && ready;
  assign rd_ok  = sel && !we && ready;
  // Mirror lets alias reads be judged without trusting the design
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      en_m <= '0;
    end else if (wr_ok && off == `PTE_OFF_IRQ_EN_SET) begin
      en_m <= en_m | (wdata & EN_MASK);
    end else if (wr_ok && off == `PTE_OFF_IRQ_EN_CLEAR) begin
      en_m <= en_m & ~wdata;
    end else if (wr_ok && off == `PTE_OFF_IRQ_EN) begin
      en_m <= wdata & EN_MASK;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  ready_one_cycle_a: assert property (ready |=> !ready)
    else $error("ready held beyond one cycle");
  take_answer_a: assert property (sel && !ready && in_win |=> ready)
    else $error("window access not answered next cycle");
  foreign_ignored_a: assert property (sel && !in_win |=> !ready)
    else $error("foreign address answered");
  id_readback_a: assert property (
    rd_ok && off == `PTE_OFF_IDREG |-> rdata == ID_VAL)
    else $error("identifier read wrong");
  en_alias_read_a: assert property (
    rd_ok && (off == `PTE_OFF_IRQ_EN || off == `PTE_OFF_IRQ_EN_SET
    || off == `PTE_OFF_IRQ_EN_CLEAR) |-> rdata == en_m)
    else $error("enable triplet read wrong");
  unmapped_zero_a: assert property (
    rd_ok && off > `PTE_OFF_CONFIG |-> rdata == '0)
    else $error("unmapped offset not zero");
  irq_drop_a: assert property (wr_ok && off == `PTE_OFF_IRQ_EN_CLEAR
    && wdata == `PTE_ALL_ONES |-> ##[1:4] !irq)
    else $error("irq still high after clearing enables");
  irq_gated_a: assert property ((en_m == '0) [*5] |-> !irq)
    else $error("irq high with no enable set");
  cover property (wr_ok && off == `PTE_OFF_IRQ_EN_CLEAR);
  cover property ($rose(irq));
  cover property (sel && !in_win);
endmodule
